// File: logic/wgsr_pkg.sv
// Constants and types shared by the waveform generator register bank
package wgsr_pkg;

  // ==========================================================
  // Register offsets and SRAM locations
  localparam logic [7:0] OFS_SEQ_CTRL = 8'h27;
  localparam logic [7:0] OFS_SRAM_PTR = 8'h2b;
  localparam logic [7:0] OFS_SRAM_DATA = 8'h2c;
  localparam logic [7:0] SRAM_WAVE_CFG = 8'h20;
  localparam logic [7:0] SRAM_WAVE_MAX = 8'h21;
  localparam logic [7:0] SRAM_WAVE_MIN = 8'h22;

  // ==========================================================
  // Field positions
  localparam int SEQ_EN_BIT = 0;
  localparam int SEQ_RUN_BIT = 1;
  localparam int SEQ_ABORT_BIT = 2;
  localparam int SHAPE_LSB = 8;
  localparam int CSTEP_LSB = 4;
  localparam int TSTEP_LSB = 0;
  localparam int LIMIT_LSB = 6;

  // ==========================================================
  // Reset values
  localparam logic [15:0] SEQ_CTRL_RST = 16'h0003;
  localparam logic [7:0] SRAM_PTR_RST = 8'h00;
  localparam logic [15:0] SRAM_DATA_RST = 16'h0000;
  localparam logic [15:0] WAVE_CFG_RST = 16'h007a;
  localparam logic [15:0] WAVE_MAX_RST = 16'hb900;
  localparam logic [15:0] WAVE_MIN_RST = 16'h1900;

  // ==========================================================
  // Shape codes
  localparam logic [2:0] SHAPE_TRI = 3'h0;
  localparam logic [2:0] SHAPE_SAW_UP = 3'h1;
  localparam logic [2:0] SHAPE_SAW_DN = 3'h2;
  localparam logic [2:0] SHAPE_OFF = 3'h7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TSTEP_01_NS = 4000;
  localparam int TSTEP_02_NS = 8000;
  localparam int TSTEP_03_NS = 12000;
  localparam int TSTEP_04_NS = 18000;
  localparam int TSTEP_05_NS = 27040;
  localparam int TSTEP_06_NS = 40480;
  localparam int TSTEP_07_NS = 60720;
  localparam int TSTEP_08_NS = 91120;
  localparam int TSTEP_09_NS = 136720;
  localparam int TSTEP_10_NS = 277680;
  localparam int TSTEP_11_NS = 418640;
  localparam int TSTEP_12_NS = 575600;
  localparam int TSTEP_13_NS = 732560;
  localparam int TSTEP_14_NS = 2563920;
  localparam int TSTEP_15_NS = 5127920;

  function automatic int ns_to_cyc(input int t_ns);
    ns_to_cyc = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam logic [15:0] TSTEP_01_CYC = 16'(ns_to_cyc(TSTEP_01_NS));
  localparam logic [15:0] TSTEP_02_CYC = 16'(ns_to_cyc(TSTEP_02_NS));
  localparam logic [15:0] TSTEP_03_CYC = 16'(ns_to_cyc(TSTEP_03_NS));
  localparam logic [15:0] TSTEP_04_CYC = 16'(ns_to_cyc(TSTEP_04_NS));
  localparam logic [15:0] TSTEP_05_CYC = 16'(ns_to_cyc(TSTEP_05_NS));
  localparam logic [15:0] TSTEP_06_CYC = 16'(ns_to_cyc(TSTEP_06_NS));
  localparam logic [15:0] TSTEP_07_CYC = 16'(ns_to_cyc(TSTEP_07_NS));
  localparam logic [15:0] TSTEP_08_CYC = 16'(ns_to_cyc(TSTEP_08_NS));
  localparam logic [15:0] TSTEP_09_CYC = 16'(ns_to_cyc(TSTEP_09_NS));
  localparam logic [15:0] TSTEP_10_CYC = 16'(ns_to_cyc(TSTEP_10_NS));

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_RUN = 2'b10
  } wgsr_gen_t;

  typedef struct packed {
    logic abort;
    logic run;
    logic enable;
  } wgsr_seq_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } wgsr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } wgsr_rsp_t;

  typedef struct packed {
    wgsr_seq_t seq;
    logic [7:0] ptr;
    logic [15:0] cfg;
    logic [15:0] maxw;
    logic [15:0] minw;
    wgsr_gen_t gen;
    logic [9:0] code;
    logic down;
    logic [15:0] tcnt;
    logic [15:0] rdata;
    logic rvalid;
  } wgsr_state_t;

endpackage

// File: logic/wgsr_regs.sv
// Register bank with indirect SRAM window and waveform generator
// What this block does
// - Writing 1 to control bit 2 aborts the sequencer, 0 clears the abort, reset is 0.
// - Control bit 1 starts the sequencer when set and stops it when clear, only with enable.
// - Control bit 0 enables the sequencer when 1, disables it when 0, and resets to 1.
// - Writing bits 7-0 of the pointer register selects the SRAM word for the next access.
// - Each read or write through the data port advances the pointer by one.
// - A data port write stores the word at the pointer, a read returns the word there.
// - Shape field 10-8 picks triangle, rising saw, falling saw, or off with 111.
// - Code step field 6-4 sets 1, 2, 3, 4, 6, 8, 16 or 32 LSB per step.
// - Time step field 3-0 sets the dwell per step from 4 us up to 5127.92 us, 0 is invalid.
// - The waveform configuration word resets to 007Ah and the host keeps reserved bits zero.
// - The upper limit is bits 15-6 of the maximum word, resetting to 2E4h.
// - The lower limit is bits 15-6 of the SRAM word at 22h, resetting to 064h.
`timescale 1ns/100ps
`default_nettype none

module wgsr_regs #(
  parameter logic [15:0] TSTEP_11_CYC = 16'(wgsr_pkg::ns_to_cyc(wgsr_pkg::TSTEP_11_NS)),
  parameter logic [15:0] TSTEP_12_CYC = 16'(wgsr_pkg::ns_to_cyc(wgsr_pkg::TSTEP_12_NS)),
  parameter logic [15:0] TSTEP_13_CYC = 16'(wgsr_pkg::ns_to_cyc(wgsr_pkg::TSTEP_13_NS)),
  parameter logic [15:0] TSTEP_14_CYC = 16'(wgsr_pkg::ns_to_cyc(wgsr_pkg::TSTEP_14_NS)),
  parameter logic [15:0] TSTEP_15_CYC = 16'(wgsr_pkg::ns_to_cyc(wgsr_pkg::TSTEP_15_NS))
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire wgsr_pkg::wgsr_req_t req,
  output var wgsr_pkg::wgsr_rsp_t rsp,
  output var wgsr_pkg::wgsr_seq_t seq_ctrl,
  output logic [9:0] wave_code,
  output logic wave_active
);

  // ==========================================================
  // Reset image
  localparam wgsr_pkg::wgsr_state_t ST_RST = '{
    seq: wgsr_pkg::wgsr_seq_t'(wgsr_pkg::SEQ_CTRL_RST[2:0]),
    ptr: wgsr_pkg::SRAM_PTR_RST,
    cfg: wgsr_pkg::WAVE_CFG_RST,
    maxw: wgsr_pkg::WAVE_MAX_RST,
    minw: wgsr_pkg::WAVE_MIN_RST,
    gen: wgsr_pkg::GEN_IDLE,
    code: wgsr_pkg::WAVE_MIN_RST[15:6],
    down: 1'b0,
    tcnt: 16'h0000,
    rdata: wgsr_pkg::SRAM_DATA_RST,
    rvalid: 1'b0
  };

  wgsr_pkg::wgsr_state_t st_r;
  wgsr_pkg::wgsr_state_t st_nxt;
  logic [15:0] mem [256];
  logic mem_we;
  logic [15:0] sram_word;
  logic data_acc;
  logic [2:0] shape;
  logic shape_ok;
  logic gen_go;
  logic [10:0] step_v;
  logic [10:0] up_v;
  logic [10:0] dn_v;
  logic [10:0] hi_v;
  logic [10:0] lo_v;
  logic [15:0] dwell_v;

  // ==========================================================
  // Decoders
  function automatic logic [10:0] step_lsb(input logic [2:0] c);
    case (c)
      3'h4: step_lsb = 11'h006;
      3'h5: step_lsb = 11'h008;
      3'h6: step_lsb = 11'h010;
      3'h7: step_lsb = 11'h020;
      default: step_lsb = {8'h00, c} + 11'h001;
    endcase
  endfunction

  function automatic logic [15:0] dwell_cyc(input logic [3:0] c);
    case (c)
      4'h1: dwell_cyc = wgsr_pkg::TSTEP_01_CYC;
      4'h2: dwell_cyc = wgsr_pkg::TSTEP_02_CYC;
      4'h3: dwell_cyc = wgsr_pkg::TSTEP_03_CYC;
      4'h4: dwell_cyc = wgsr_pkg::TSTEP_04_CYC;
      4'h5: dwell_cyc = wgsr_pkg::TSTEP_05_CYC;
      4'h6: dwell_cyc = wgsr_pkg::TSTEP_06_CYC;
      4'h7: dwell_cyc = wgsr_pkg::TSTEP_07_CYC;
      4'h8: dwell_cyc = wgsr_pkg::TSTEP_08_CYC;
      4'h9: dwell_cyc = wgsr_pkg::TSTEP_09_CYC;
      4'ha: dwell_cyc = wgsr_pkg::TSTEP_10_CYC;
      4'hb: dwell_cyc = TSTEP_11_CYC;
      4'hc: dwell_cyc = TSTEP_12_CYC;
      4'hd: dwell_cyc = TSTEP_13_CYC;
      4'he: dwell_cyc = TSTEP_14_CYC;
      4'hf: dwell_cyc = TSTEP_15_CYC;
      default: dwell_cyc = 16'h0001;
    endcase
  endfunction

  // ==========================================================
  // Generator operands
  // shape decode
  assign shape = st_r.cfg[wgsr_pkg::SHAPE_LSB +: 3];
  assign shape_ok = (shape == wgsr_pkg::SHAPE_TRI) || (shape == wgsr_pkg::SHAPE_SAW_UP) ||
                    (shape == wgsr_pkg::SHAPE_SAW_DN);
  assign gen_go = st_r.seq.enable && st_r.seq.run && !st_r.seq.abort && shape_ok &&
                  (st_r.cfg[wgsr_pkg::TSTEP_LSB +: 4] != 4'h0);
  assign step_v = step_lsb(st_r.cfg[wgsr_pkg::CSTEP_LSB +: 3]);
  assign dwell_v = dwell_cyc(st_r.cfg[wgsr_pkg::TSTEP_LSB +: 4]);
  assign up_v = {1'b0, st_r.code} + step_v;
  assign dn_v = {1'b0, st_r.code} - step_v;
  assign hi_v = {1'b0, st_r.maxw[wgsr_pkg::LIMIT_LSB +: 10]};
  assign lo_v = {1'b0, st_r.minw[wgsr_pkg::LIMIT_LSB +: 10]};
  assign data_acc = (req.wr || req.rd) && (req.addr == wgsr_pkg::OFS_SRAM_DATA);

  // ==========================================================
  // SRAM array
  // waveform words live behind the window
  always_comb begin
    case (st_r.ptr)
      wgsr_pkg::SRAM_WAVE_CFG: sram_word = st_r.cfg;
      wgsr_pkg::SRAM_WAVE_MAX: sram_word = st_r.maxw;
      wgsr_pkg::SRAM_WAVE_MIN: sram_word = st_r.minw;
      default: sram_word = mem[st_r.ptr];
    endcase
  end

  assign mem_we = ce && req.wr && (req.addr == wgsr_pkg::OFS_SRAM_DATA);

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[st_r.ptr] <= req.wdata;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (req.wr) begin
      case (req.addr)
        wgsr_pkg::OFS_SEQ_CTRL: st_nxt.seq = wgsr_pkg::wgsr_seq_t'(req.wdata[2:0]);
        wgsr_pkg::OFS_SRAM_PTR: st_nxt.ptr = req.wdata[7:0];
        wgsr_pkg::OFS_SRAM_DATA: begin
          case (st_r.ptr)
            wgsr_pkg::SRAM_WAVE_CFG: st_nxt.cfg = req.wdata;
            wgsr_pkg::SRAM_WAVE_MAX: st_nxt.maxw = req.wdata;
            wgsr_pkg::SRAM_WAVE_MIN: st_nxt.minw = req.wdata;
            default: st_nxt.cfg = st_r.cfg;
          endcase
        end
        default: st_nxt.ptr = st_r.ptr;
      endcase
    end else if (req.rd) begin
      st_nxt.rvalid = 1'b1;
      case (req.addr)
        wgsr_pkg::OFS_SEQ_CTRL: st_nxt.rdata = {13'h0000, st_r.seq};
        wgsr_pkg::OFS_SRAM_PTR: st_nxt.rdata = {8'h00, st_r.ptr};
        wgsr_pkg::OFS_SRAM_DATA: st_nxt.rdata = sram_word;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    if (data_acc) begin
      st_nxt.ptr = st_r.ptr + 8'h01;
    end

    case (st_r.gen)
      wgsr_pkg::GEN_IDLE: begin
        if (gen_go) begin
          st_nxt.gen = wgsr_pkg::GEN_RUN;
          st_nxt.tcnt = dwell_v - 16'h0001;
        end
      end
      wgsr_pkg::GEN_RUN: begin
        if (!gen_go) begin
          st_nxt.gen = wgsr_pkg::GEN_IDLE;
        end else if (st_r.tcnt != 16'h0000) begin
          st_nxt.tcnt = st_r.tcnt - 16'h0001;
        end else begin
          st_nxt.tcnt = dwell_v - 16'h0001;
          case (shape)
            wgsr_pkg::SHAPE_TRI: begin
              if (!st_r.down) begin
                if (up_v >= hi_v) begin
                  st_nxt.code = hi_v[9:0];
                  st_nxt.down = 1'b1;
                end else begin
                  st_nxt.code = up_v[9:0];
                end
              end else if (dn_v[10] || (dn_v <= lo_v)) begin
                st_nxt.code = lo_v[9:0];
                st_nxt.down = 1'b0;
              end else begin
                st_nxt.code = dn_v[9:0];
              end
            end
            wgsr_pkg::SHAPE_SAW_UP: begin
              if ({1'b0, st_r.code} >= hi_v) begin
                st_nxt.code = lo_v[9:0];
              end else if (up_v > hi_v) begin
                st_nxt.code = hi_v[9:0];
              end else begin
                st_nxt.code = up_v[9:0];
              end
            end
            default: begin
              if ({1'b0, st_r.code} <= lo_v) begin
                st_nxt.code = hi_v[9:0];
              end else if (dn_v[10] || (dn_v < lo_v)) begin
                st_nxt.code = lo_v[9:0];
              end else begin
                st_nxt.code = dn_v[9:0];
              end
            end
          endcase
        end
      end
      default: st_nxt.gen = wgsr_pkg::GEN_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  // whole state reset image
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rsp = '{valid: st_r.rvalid, data: st_r.rdata};
  assign seq_ctrl = st_r.seq;
  assign wave_code = st_r.code;
  // Run state bit of the one-hot code, taken straight from the register
  assign wave_active = st_r.gen[1];

  // ==========================================================
  // Checks
  abort_stops_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && st_r.seq.abort) |=> (st_r.gen == wgsr_pkg::GEN_IDLE))
    else $error("Generator ran while aborted");

  run_needs_en_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.gen == wgsr_pkg::GEN_RUN) |-> $past(st_r.seq.enable && st_r.seq.run))
    else $error("Generator ran without enable and start");

  disable_idles_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && req.wr && (req.addr == wgsr_pkg::OFS_SEQ_CTRL) && !req.wdata[0]) ##1 ce
    |=> (st_r.gen == wgsr_pkg::GEN_IDLE))
    else $error("Generator kept running after disable");

  ptr_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && req.wr && (req.addr == wgsr_pkg::OFS_SRAM_PTR)) |=> (st_r.ptr == $past(req.wdata[7:0])))
    else $error("Pointer not loaded");

  ptr_incr_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && data_acc) |=> (st_r.ptr == $past(st_r.ptr) + 8'h01))
    else $error("Pointer did not advance");

  data_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && req.rd && !req.wr && (req.addr == wgsr_pkg::OFS_SRAM_DATA)) |=>
    (rsp.valid && (rsp.data == $past(sram_word))))
    else $error("Data port read returned wrong word");

  shape_off_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && (shape == wgsr_pkg::SHAPE_OFF)) |=> !wave_active)
    else $error("Generator ran with shape off");

  saw_step_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wave_active && gen_go && (st_r.tcnt == 16'h0000) &&
     (shape == wgsr_pkg::SHAPE_SAW_UP) && ({1'b0, st_r.code} < hi_v) && (up_v <= hi_v))
    |=> (wave_code == $past(up_v[9:0])))
    else $error("Code step size wrong");

  dwell_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !wave_active && gen_go) |=> (wave_active && (st_r.tcnt == $past(dwell_v) - 16'h0001)))
    else $error("Dwell count not loaded on start");

  tri_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wave_active && gen_go && (st_r.tcnt == 16'h0000) && (shape == wgsr_pkg::SHAPE_TRI) &&
     ({1'b0, st_r.code} <= hi_v) && ({1'b0, st_r.code} >= lo_v) && (lo_v <= hi_v))
    |=> (({1'b0, wave_code} <= $past(hi_v)) && ({1'b0, wave_code} >= $past(lo_v))))
    else $error("Triangle left its limits");

  saw_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && wave_active && gen_go && (st_r.tcnt == 16'h0000) &&
     (shape == wgsr_pkg::SHAPE_SAW_UP) && ({1'b0, st_r.code} >= hi_v))
    |=> (wave_code == $past(lo_v[9:0])))
    else $error("Sawtooth did not wrap to minimum");

endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the waveform generator register bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk;
  logic rstn;
  logic ce;
  wgsr_pkg::wgsr_req_t req;
  wgsr_pkg::wgsr_rsp_t rsp;
  wgsr_pkg::wgsr_seq_t seq_ctrl;
  logic [9:0] wave_code;
  logic wave_active;
  int err_count = 0;
  int tests_run = 0;
  int lo, hi, stp, dwl, cnt;
  logic [2:0] shp;
  logic mon_on = 1'b0;
  logic m_valid = 1'b0;
  logic m_down = 1'b0;
  logic [9:0] prev;
  logic [9:0] held;
  logic [15:0] mem [8];
  logic [15:0] v;
  logic [7:0] base;
  logic [3:0] ts_tab [8] = '{4'h1, 4'h2, 4'h3, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};

  // Long dwell codes shortened to keep the run brief
  wgsr_regs #(
    .TSTEP_11_CYC(16'h0008),
    .TSTEP_12_CYC(16'h0009),
    .TSTEP_13_CYC(16'h000a),
    .TSTEP_14_CYC(16'h000b),
    .TSTEP_15_CYC(16'h000c)
  ) dut (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .req(req),
    .rsp(rsp),
    .seq_ctrl(seq_ctrl),
    .wave_code(wave_code),
    .wave_active(wave_active)
  );

  always #50 clk = ~clk;

  // ==========================================================
  // Helpers
  task automatic results();
    $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask

  task automatic idle();
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(16'(rsp.valid), 16'h0001);
    chk(rsp.data, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    req <= '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic reset_check();
    @(negedge clk);
    chk(16'(seq_ctrl), 16'h0003);
    chk(16'(wave_code), 16'h0064);
    chk(rsp.data, 16'h0000);
    rd(wgsr_pkg::OFS_SEQ_CTRL, 16'h0003);
    rd(wgsr_pkg::OFS_SRAM_PTR, 16'h0000);
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h0020);
    rd(wgsr_pkg::OFS_SRAM_DATA, 16'h007a);
    rd(wgsr_pkg::OFS_SRAM_DATA, 16'hb900);
    rd(wgsr_pkg::OFS_SRAM_DATA, 16'h1900);
  endtask

  function automatic int step_of(input logic [2:0] c);
    case (c)
      3'h4: step_of = 6;
      3'h5: step_of = 8;
      3'h6: step_of = 16;
      3'h7: step_of = 32;
      default: step_of = int'(c) + 1;
    endcase
  endfunction

  // Codes Bh..Fh map onto the shortened parameters 8..12
  function automatic int dwell_of(input logic [3:0] t);
    case (t)
      4'h1: dwell_of = 40;
      4'h2: dwell_of = 80;
      4'h3: dwell_of = 120;
      default: dwell_of = int'(t) - 3;
    endcase
  endfunction

  function automatic int nxt(input int c);
    if (shp == 3'h1) nxt = (c >= hi) ? lo : ((c + stp > hi) ? hi : c + stp);
    else if (shp == 3'h2) nxt = (c <= lo) ? hi : ((c - stp < lo) ? lo : c - stp);
    else if (!m_down) nxt = (c + stp >= hi) ? hi : c + stp;
    else nxt = (c - stp <= lo) ? lo : c - stp;
  endfunction

  // ==========================================================
  // Generator monitor: first change after a start only seeds the model
  always @(negedge clk) begin
    if (mon_on && wave_active === 1'b1) begin
      cnt = cnt + 1;
      if (wave_code !== prev) begin
        if (m_valid) begin
          chk(16'(cnt), 16'(dwl));
          chk(16'(wave_code), 16'(nxt(int'(prev))));
        end
        if (int'(wave_code) >= hi) m_down = 1'b1;
        else if (int'(wave_code) <= lo) m_down = 1'b0;
        else m_down = (wave_code < prev);
        prev = wave_code;
        cnt = 0;
        m_valid = 1'b1;
      end
    end else begin
      m_valid = 1'b0;
      prev = wave_code;
      cnt = 0;
    end
  end

  task automatic gen_run(input logic [2:0] sh, input logic [2:0] sc, input logic [3:0] ts);
    mon_on = 1'b0;
    wr(wgsr_pkg::OFS_SEQ_CTRL, 16'h0000);
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h0020);
    wr(wgsr_pkg::OFS_SRAM_DATA, {5'h00, sh, 1'b0, sc, ts});
    wr(wgsr_pkg::OFS_SEQ_CTRL, 16'h0003);
    idle();
    shp = sh;
    stp = step_of(sc);
    dwl = dwell_of(ts);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'(wave_active), 16'(sh <= 3'h2 && ts != 4'h0));
    @(posedge clk);
    mon_on = 1'b1;
    repeat (24 * dwl) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    req = '0;
    void'($urandom(92));
    do_reset();
    reset_check();
    for (int c = 0; c < 8; c++) begin
      wr(wgsr_pkg::OFS_SEQ_CTRL, 16'(c));
      idle();
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(16'(seq_ctrl), 16'(c));
      chk(16'(wave_active), 16'(c == 3));
      rd(wgsr_pkg::OFS_SEQ_CTRL, 16'(c));
    end
    base = 8'($urandom_range(8'h30, 8'he0));
    wr(wgsr_pkg::OFS_SRAM_PTR, {8'h00, base});
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'($urandom());
      wr(wgsr_pkg::OFS_SRAM_DATA, mem[i]);
    end
    rd(wgsr_pkg::OFS_SRAM_PTR, {8'h00, base + 8'h08});
    wr(wgsr_pkg::OFS_SRAM_PTR, {8'h00, base});
    for (int i = 0; i < 8; i++) begin
      rd(wgsr_pkg::OFS_SRAM_DATA, mem[i]);
    end
    v = 16'($urandom());
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h00ff);
    wr(wgsr_pkg::OFS_SRAM_DATA, v);
    rd(wgsr_pkg::OFS_SRAM_PTR, 16'h0000);
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h00ff);
    rd(wgsr_pkg::OFS_SRAM_DATA, v);
    wr(8'h00, 16'h1234);
    rd(wgsr_pkg::OFS_SRAM_PTR, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rd(8'($urandom_range(8'h30, 8'hff)), 16'h0000);
    end
    // Narrow limits around the reset code so that turns happen often
    lo = 32'h64 - $urandom_range(0, 30);
    hi = 32'h64 + $urandom_range(10, 40);
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h0021);
    wr(wgsr_pkg::OFS_SRAM_DATA, {10'(hi), 6'h00});
    wr(wgsr_pkg::OFS_SRAM_DATA, {10'(lo), 6'h15});
    idle();
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        gen_run(3'(s), 3'(c), ts_tab[$urandom_range(0, 7)]);
      end
    end
    for (int s = 3; s < 8; s++) begin
      gen_run(3'(s), 3'h7, 4'hb);
    end
    gen_run(3'h0, 3'h7, 4'h0);
    gen_run(3'h1, 3'h0, 4'hb);
    mon_on = 1'b0;
    @(posedge clk);
    ce <= 1'b0;
    wr(wgsr_pkg::OFS_SRAM_PTR, 16'h0055);
    idle();
    @(negedge clk);
    held = wave_code;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk(16'(wave_code), 16'(held));
    rd(wgsr_pkg::OFS_SRAM_PTR, 16'h0021);
    do_reset();
    reset_check();
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(64'd80000 * 64'd100);
    err_count++;
    results();
  end
endmodule

`default_nettype wire
